/* File: osr_core.sv */
// osr_core: operation summary set and its six sub-sets
// assumes activity and result inputs come from engines on ref_clk
//
// What this block does
// - top bits: cal0 meas4 trig5 sense10 llf11 ulf12
// - top bits 13-15 unused, bit 15 zero
// - calibrating set: channel bits 1 and 2
// - zeroing or calibration start raises calibrating
// - calibrate-all start also raises calibrating
// - run completion drops calibrating bit
// - lower-limit set: ch1,ch2,upper,lower at 1-4
// - lower-limit test failure sets its bit
// - limit bit clears only on passing test without failure
// - measuring set bits high during measurement
// - measuring bit drops when measurement completes
// - sensor-read bits follow reading one cycle later
// - trigger bits set on wait-for-trigger entry
// - trigger bits clear on idle entry
// - upper-limit set: same map, set on fail
// - preset loads enable and filter values
// - preset leaves condition and events unchanged
// - every set offers the common operations
// - event read returns then clears bits
// - condition read leaves bits unchanged
// - filtered edges latch event bits
`timescale 1ns/10ps
module osr_core import osr_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire osr_cmd_t    cmd,
  input  wire logic        preset_req,
  input  wire logic [1:0]  zero_start,
  input  wire logic [1:0]  cal_start,
  input  wire logic        cal_all_start,
  input  wire logic [1:0]  cal_done,
  input  wire logic [3:0]  llf_fail,
  input  wire logic [3:0]  llf_pass,
  input  wire logic [3:0]  ulf_fail,
  input  wire logic [3:0]  ulf_pass,
  input  wire logic [1:0]  meas_active,
  input  wire logic [1:0]  sensor_reading,
  input  wire logic [1:0]  trig_wait_enter,
  input  wire logic [1:0]  trig_idle_enter,
  output logic             rsp_valid,
  output logic      [15:0] rsp_data,
  output logic             op_summary
);

  typedef struct packed {
    logic [1:0]  cal;
    logic [3:0]  llf;
    logic [3:0]  ulf;
    logic [1:0]  meas;
    logic [1:0]  sense;
    logic [1:0]  trig;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        summary;
  } osr_core_state_t;

  osr_core_state_t s;
  osr_core_state_t next_s;
  logic [1:0]      rst_sync;
  logic            rst_n;
  logic [15:0]     set_cond [NUM_SETS];
  logic [15:0]     set_rdata [NUM_SETS];
  logic            set_sum [NUM_SETS];
  logic [1:0]      cal_set;

  // ==========================================================
  // reset release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================
  // condition words
  function automatic logic [15:0] ch_word(input logic [1:0] ch);
    logic [15:0] w;
    w = ALL_ZEROS;
    w[CH1_BIT] = ch[0];
    w[CH2_BIT] = ch[1];
    return w;
  endfunction : ch_word

  function automatic logic [15:0] lim_word(input logic [3:0] f);
    logic [15:0] w;
    w = ch_word(f[1:0]);
    w[UPWIN_BIT] = f[2];
    w[LOWIN_BIT] = f[3];
    return w;
  endfunction : lim_word

  always_comb begin
    set_cond[SET_TOP] = ALL_ZEROS;
    set_cond[SET_TOP][TOP_CAL_BIT]   = set_sum[SET_CAL];
    set_cond[SET_TOP][TOP_MEAS_BIT]  = set_sum[SET_MEAS];
    set_cond[SET_TOP][TOP_TRIG_BIT]  = set_sum[SET_TRIG];
    set_cond[SET_TOP][TOP_SENSE_BIT] = set_sum[SET_SENSE];
    set_cond[SET_TOP][TOP_LLF_BIT]   = set_sum[SET_LLF];
    set_cond[SET_TOP][TOP_ULF_BIT]   = set_sum[SET_ULF];
    set_cond[SET_CAL]   = ch_word(s.cal);
    set_cond[SET_LLF]   = lim_word(s.llf);
    set_cond[SET_MEAS]  = ch_word(s.meas);
    set_cond[SET_SENSE] = ch_word(s.sense);
    set_cond[SET_TRIG]  = ch_word(s.trig);
    set_cond[SET_ULF]   = lim_word(s.ulf);
  end

  // ==========================================================
  // the seven sets
  for (genvar g = 0; g < NUM_SETS; g++) begin : g_set
    osr_set #(
      .TOP_PRESET (g == 0)
    ) u_set (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .cond    (set_cond[g]),
      .hit     (cmd.valid && cmd.sel == 3'(g)),
      .op      (cmd.op),
      .wdata   (cmd.data),
      .preset  (preset_req),
      .rdata   (set_rdata[g]),
      .summary (set_sum[g])
    );
  end

  // ==========================================================
  // condition tracking and answers
  assign cal_set = zero_start | cal_start | {2{cal_all_start}};

  always_comb begin
    next_s = s;
    next_s.cal  = cal_set | (s.cal & ~cal_done);
    next_s.llf  = llf_fail | (s.llf & ~llf_pass);
    next_s.ulf  = ulf_fail | (s.ulf & ~ulf_pass);
    next_s.meas = meas_active;
    next_s.sense = sensor_reading;
    next_s.trig = trig_wait_enter | (s.trig & ~trig_idle_enter);
    next_s.rsp_valid = cmd.valid && op_is_rd(cmd.op);
    next_s.rsp_data = ALL_ZEROS;
    if (cmd.valid && op_is_rd(cmd.op) && cmd.sel < 3'(NUM_SETS)) begin
      next_s.rsp_data = set_rdata[cmd.sel] & VALID_MASK;
    end
    next_s.summary = set_sum[SET_TOP];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rsp_valid  = s.rsp_valid;
  assign rsp_data   = s.rsp_data;
  assign op_summary = s.summary;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_cal_start;
    zero_start[0] || cal_start[0] |=> set_cond[SET_CAL][CH1_BIT];
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibrating not raised");

  property p_cal_all;
    cal_all_start |=> set_cond[SET_CAL][CH2_BIT:CH1_BIT] == 2'h3;
  endproperty
  a_cal_all: assert property (p_cal_all)
    else $error("calibrate-all not raised");

  property p_cal_done;
    cal_done[1] && !cal_set[1] |=> !set_cond[SET_CAL][CH2_BIT];
  endproperty
  a_cal_done: assert property (p_cal_done)
    else $error("calibrating not dropped");

  property p_llf_fail;
    llf_fail[3] |=> set_cond[SET_LLF][LOWIN_BIT];
  endproperty
  a_llf_fail: assert property (p_llf_fail)
    else $error("lower fail not set");

  property p_ulf_keep;
    set_cond[SET_ULF][UPWIN_BIT] && !ulf_pass[2]
      |=> set_cond[SET_ULF][UPWIN_BIT];
  endproperty
  a_ulf_keep: assert property (p_ulf_keep)
    else $error("upper fail cleared without pass");

  property p_meas_follow;
    ##1 set_cond[SET_MEAS][CH2_BIT] == $past(meas_active[1]);
  endproperty
  a_meas_follow: assert property (p_meas_follow)
    else $error("measuring bit does not follow activity");

  sequence s_trig_enter;
    trig_wait_enter[0] && !trig_idle_enter[0];
  endsequence
  sequence s_trig_wait;
    set_cond[SET_TRIG][CH1_BIT] ##0 !trig_idle_enter[0];
  endsequence

  property p_trig_cycle;
    s_trig_enter ##1 s_trig_wait ##1 trig_idle_enter[0]
      |=> !set_cond[SET_TRIG][CH1_BIT] || $past(trig_wait_enter[0]);
  endproperty
  a_trig_cycle: assert property (p_trig_cycle)
    else $error("trigger bit not cleared on idle");

  property p_trig_enter;
    s_trig_enter |=> set_cond[SET_TRIG][CH1_BIT];
  endproperty
  a_trig_enter: assert property (p_trig_enter)
    else $error("trigger bit not set on wait");

  property p_trig_ch2;
    trig_wait_enter[1] |=> set_cond[SET_TRIG][CH2_BIT];
  endproperty
  a_trig_ch2: assert property (p_trig_ch2)
    else $error("channel two trigger bit not set");

  property p_cal_ch2;
    zero_start[1] || cal_start[1] |=> set_cond[SET_CAL][CH2_BIT];
  endproperty
  a_cal_ch2: assert property (p_cal_ch2)
    else $error("channel two calibrating not raised");

  property p_cal_hold;
    set_cond[SET_CAL][CH1_BIT] && !cal_done[0]
      |=> set_cond[SET_CAL][CH1_BIT];
  endproperty
  a_cal_hold: assert property (p_cal_hold)
    else $error("calibrating dropped before completion");

  property p_llf_pass;
    llf_pass[0] && !llf_fail[0] |=> !set_cond[SET_LLF][CH1_BIT];
  endproperty
  a_llf_pass: assert property (p_llf_pass)
    else $error("lower fail not cleared by pass");

  property p_llf_keep;
    set_cond[SET_LLF][CH2_BIT] && !llf_pass[1]
      |=> set_cond[SET_LLF][CH2_BIT];
  endproperty
  a_llf_keep: assert property (p_llf_keep)
    else $error("lower fail cleared without pass");

  property p_ulf_fail;
    ulf_fail[1] |=> set_cond[SET_ULF][CH2_BIT];
  endproperty
  a_ulf_fail: assert property (p_ulf_fail)
    else $error("upper fail not set");

  property p_meas_rise;
    meas_active[0] |=> set_cond[SET_MEAS][CH1_BIT];
  endproperty
  a_meas_rise: assert property (p_meas_rise)
    else $error("measuring bit not raised");

  property p_sense_follow;
    ##1 set_cond[SET_SENSE][CH2_BIT:CH1_BIT] == $past(sensor_reading);
  endproperty
  a_sense_follow: assert property (p_sense_follow)
    else $error("sensor-read bits do not follow reading");

  property p_rsp_pulse;
    cmd.valid && op_is_rd(cmd.op) |=> rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse)
    else $error("read command not answered");

  property p_no_rsp;
    !(cmd.valid && op_is_rd(cmd.op)) |=> !rsp_valid && rsp_data == ALL_ZEROS;
  endproperty
  a_no_rsp: assert property (p_no_rsp)
    else $error("answer without read command");

  property p_cal_unused;
    rsp_valid && $past(cmd.sel) == SET_CAL && $past(cmd.op) == OP_COND_RD
      |-> rsp_data[15:3] == 13'h0 && !rsp_data[0];
  endproperty
  a_cal_unused: assert property (p_cal_unused)
    else $error("unused calibrating bits set");

  property p_lim_unused;
    rsp_valid && $past(cmd.sel) == SET_LLF && $past(cmd.op) == OP_COND_RD
      |-> rsp_data[15:5] == 11'h0 && !rsp_data[0];
  endproperty
  a_lim_unused: assert property (p_lim_unused)
    else $error("unused lower fail bits set");

  property p_bit15;
    rsp_valid |-> !rsp_data[15]
                  && (rsp_data[14:13] == 2'h0 || $past(cmd.sel) != SET_TOP
                      || $past(cmd.op[2:1]) != 2'h0);
  endproperty
  a_bit15: assert property (p_bit15)
    else $error("top bits 13-15 not zero");

endmodule : osr_core

/* File: osr_pkg.sv */
// osr_pkg: constants and carriers for the operation status register sets
// assumes one device clock; set indices shared by core and bench, not used by osr_set
package osr_pkg;

  // ==========================================================
  // set indices
  localparam logic [2:0] SET_TOP   = 3'h0;
  localparam logic [2:0] SET_CAL   = 3'h1;
  localparam logic [2:0] SET_LLF   = 3'h2;
  localparam logic [2:0] SET_MEAS  = 3'h3;
  localparam logic [2:0] SET_SENSE = 3'h4;
  localparam logic [2:0] SET_TRIG  = 3'h5;
  localparam logic [2:0] SET_ULF   = 3'h6;
  localparam int         NUM_SETS  = 7;

  // ==========================================================
  // top-level summary bit positions
  localparam int TOP_CAL_BIT   = 0;
  localparam int TOP_MEAS_BIT  = 4;
  localparam int TOP_TRIG_BIT  = 5;
  localparam int TOP_SENSE_BIT = 10;
  localparam int TOP_LLF_BIT   = 11;
  localparam int TOP_ULF_BIT   = 12;

  // ==========================================================
  // sub-set field positions
  localparam int CH1_BIT     = 1;
  localparam int CH2_BIT     = 2;
  localparam int UPWIN_BIT   = 3;
  localparam int LOWIN_BIT   = 4;

  // ==========================================================
  // masks and preset values
  localparam logic [15:0] VALID_MASK  = 16'h7fff;
  localparam logic [15:0] ALL_ZEROS   = 16'h0000;
  localparam logic [15:0] PRE_EN_TOP  = 16'h0000;
  localparam logic [15:0] PRE_EN_SUB  = 16'h7fff;
  localparam logic [15:0] PRE_RISE    = 16'h7fff;
  localparam logic [15:0] PRE_FALL    = 16'h0000;

  // ==========================================================
  // per-set operations
  localparam logic [2:0] OP_COND_RD = 3'h0;
  localparam logic [2:0] OP_EVT_RD  = 3'h1;
  localparam logic [2:0] OP_EN_WR   = 3'h2;
  localparam logic [2:0] OP_EN_RD   = 3'h3;
  localparam logic [2:0] OP_RISE_WR = 3'h4;
  localparam logic [2:0] OP_RISE_RD = 3'h5;
  localparam logic [2:0] OP_FALL_WR = 3'h6;
  localparam logic [2:0] OP_FALL_RD = 3'h7;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        valid;
    logic [2:0]  sel;
    logic [2:0]  op;
    logic [15:0] data;
  } osr_cmd_t;

  typedef struct packed {
    logic [15:0] prev;
    logic [15:0] evt;
    logic [15:0] en;
    logic [15:0] rising_edge_filter;
    logic [15:0] falling_edge_filter;
  } osr_set_state_t;

  function automatic logic op_is_rd(input logic [2:0] op);
    return (op == OP_COND_RD) || op[0];
  endfunction : op_is_rd

endpackage : osr_pkg

/* File: osr_set.sv */
// osr_set: one status register set with condition, event, enable
// and edge filters; assumes synchronous reset copy and same-clock inputs
`timescale 1ns/10ps
module osr_set import osr_pkg::*; #(
  parameter logic TOP_PRESET = 1'b0
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] cond,
  input  wire logic        hit,
  input  wire logic [2:0]  op,
  input  wire logic [15:0] wdata,
  input  wire logic        preset,
  output logic      [15:0] rdata,
  output logic             summary
);

  localparam logic [15:0] PRE_EN = TOP_PRESET ? PRE_EN_TOP : PRE_EN_SUB;

  osr_set_state_t s;
  osr_set_state_t next_s;
  logic [15:0]    edges;

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.prev = cond & VALID_MASK;
    edges = ((cond & ~s.prev & s.rising_edge_filter)
           | (~cond & s.prev & s.falling_edge_filter)) & VALID_MASK;
    if (hit && op == OP_EVT_RD) begin
      next_s.evt = edges;
    end else begin
      next_s.evt = s.evt | edges;
    end
    if (preset) begin
      next_s.en = PRE_EN;
      next_s.rising_edge_filter = PRE_RISE;
      next_s.falling_edge_filter = PRE_FALL;
    end else if (hit) begin
      unique case (op)
        OP_EN_WR:   next_s.en = wdata & VALID_MASK;
        OP_RISE_WR: next_s.rising_edge_filter = wdata & VALID_MASK;
        OP_FALL_WR: next_s.falling_edge_filter = wdata & VALID_MASK;
        default:    next_s.en = s.en;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{prev: ALL_ZEROS, evt: ALL_ZEROS, en: PRE_EN,
             rising_edge_filter: PRE_RISE,
             falling_edge_filter: PRE_FALL};
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // read data and summary
  always_comb begin
    unique case (op)
      OP_COND_RD: rdata = cond & VALID_MASK;
      OP_EVT_RD:  rdata = s.evt;
      OP_EN_RD:   rdata = s.en;
      OP_RISE_RD: rdata = s.rising_edge_filter;
      OP_FALL_RD: rdata = s.falling_edge_filter;
      default:    rdata = ALL_ZEROS;
    endcase
  end

  assign summary = |(s.evt & s.en);

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_evt_clear;
    hit && op == OP_EVT_RD && edges == ALL_ZEROS |=> s.evt == ALL_ZEROS;
  endproperty
  a_evt_clear: assert property (p_evt_clear)
    else $error("event not cleared by read");

  property p_preset_vals;
    preset |=> s.en == PRE_EN && s.rising_edge_filter == PRE_RISE
           && s.falling_edge_filter == PRE_FALL;
  endproperty
  a_preset_vals: assert property (p_preset_vals)
    else $error("preset values wrong");

  property p_rise_latch;
    s.rising_edge_filter[1] && !s.prev[1] && cond[1] |=> s.evt[1];
  endproperty
  a_rise_latch: assert property (p_rise_latch)
    else $error("rising edge not latched");

  property p_evt_hold;
    s.evt[2] && !(hit && op == OP_EVT_RD) |=> s.evt[2];
  endproperty
  a_evt_hold: assert property (p_evt_hold)
    else $error("event lost without read");

endmodule : osr_set

/* File: osr_core_tb_top.sv */
// osr_core_tb_top: self-checking bench for the status register sets
// assumes osr_pkg and osr_core compiled first; assertions sit in design
`timescale 1ns/10ps
module osr_core_tb_top import osr_pkg::*; ();
  // ==========================================================
  // signals
  logic        ref_clk;
  logic        arst_n;
  osr_cmd_t    cmd;
  logic        preset_req;
  logic        cal_all_start;
  logic [1:0]  zero_start, cal_start, cal_done, meas_active;
  logic [1:0]  sensor_reading, trig_wait_enter, trig_idle_enter;
  logic [3:0]  llf_fail, llf_pass, ulf_fail, ulf_pass;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic        op_summary;
  logic [15:0] exp_q[$];
  string       name_q[$];
  int          num_errors;
  int          n_tests;
  int          seed;
  logic [15:0] top_bit [7] = '{16'h0000, 16'h0001, 16'h0800, 16'h0010,
                               16'h0400, 16'h0020, 16'h1000};

  osr_core dut (.ref_clk(ref_clk), .arst_n(arst_n), .cmd(cmd),
    .preset_req(preset_req), .zero_start(zero_start),
    .cal_start(cal_start), .cal_all_start(cal_all_start),
    .cal_done(cal_done), .llf_fail(llf_fail), .llf_pass(llf_pass),
    .ulf_fail(ulf_fail), .ulf_pass(ulf_pass), .meas_active(meas_active),
    .sensor_reading(sensor_reading), .trig_wait_enter(trig_wait_enter),
    .trig_idle_enter(trig_idle_enter), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .op_summary(op_summary));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // compare and report
  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic results();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // response watcher takes the oldest note
  always @(negedge ref_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0)
        check("unexpected response", 16'h0000, 16'hffff);
      else
        check(name_q.pop_front(), exp_q.pop_front(), rsp_data);
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    check("timeout", 16'h0000, 16'h0001);
    results();
  end

  // ==========================================================
  // drivers
  task automatic req(input logic [2:0] s, input logic [2:0] o,
                     input logic [15:0] d);
    @(negedge ref_clk);
    cmd = {1'b1, s, o, d};
    @(negedge ref_clk);
    cmd.valid = 1'b0;
  endtask : req

  task automatic rd(input logic [2:0] s, input logic [2:0] o,
                    input logic [15:0] e);
    exp_q.push_back(e);
    name_q.push_back($sformatf("set%0d op%0d", s, o));
    req(s, o, 16'h0000);
  endtask : rd

  task automatic chk_presets();
    for (int s = 0; s < 7; s++) begin
      rd(s[2:0], OP_EN_RD, (s == 0) ? 16'h0000 : 16'h7fff);
      rd(s[2:0], OP_RISE_RD, 16'h7fff);
      rd(s[2:0], OP_FALL_RD, 16'h0000);
    end
  endtask : chk_presets

  // raise or drop one source, preset pulsed with every raise
  task automatic src(input logic [2:0] s, input int i, input int r,
                     input logic on);
    @(negedge ref_clk);
    case (s)
      SET_CAL: begin
        if (!on) cal_done = (r == 2) ? 2'h3 : 2'h1 << i;
        else if (r == 2) cal_all_start = 1'b1;
        else if (r % 2) cal_start[i] = 1'b1;
        else zero_start[i] = 1'b1;
      end
      SET_LLF: if (on) llf_fail[i] = 1'b1; else llf_pass[i] = 1'b1;
      SET_MEAS: meas_active[i] = on;
      SET_SENSE: sensor_reading[i] = on;
      SET_TRIG: begin
        if (on) trig_wait_enter[i] = 1'b1;
        else trig_idle_enter[i] = 1'b1;
      end
      default: if (on) ulf_fail[i] = 1'b1; else ulf_pass[i] = 1'b1;
    endcase
    preset_req = on;
    @(negedge ref_clk);
    {zero_start, cal_start, cal_all_start, cal_done, preset_req} = '0;
    {llf_fail, llf_pass, ulf_fail, ulf_pass} = '0;
    {trig_wait_enter, trig_idle_enter} = '0;
    repeat (3) @(negedge ref_clk);
  endtask : src

  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] w;
    logic [15:0] m;
    int          i;
    seed = 61;
    arst_n = 1'b0;
    cmd = '0;
    {zero_start, cal_start, cal_all_start, cal_done, preset_req} = '0;
    {llf_fail, llf_pass, ulf_fail, ulf_pass} = '0;
    {trig_wait_enter, trig_idle_enter} = '0;
    {meas_active, sensor_reading} = '0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk_presets();
    for (int s = 0; s < 8; s++)
      for (int o = 2; o < 8; o += 2) begin
        w = 16'($random(seed));
        req(s[2:0], o[2:0], w);
        rd(s[2:0], o[2:0] + 3'h1, (s == 7) ? 16'h0 : w & 16'h7fff);
      end
    @(negedge ref_clk);
    preset_req = 1'b1;
    @(negedge ref_clk);
    preset_req = 1'b0;
    chk_presets();
    for (int s = 1; s < 7; s++)
      for (int r = 0; r < 4; r++) begin
        i = (s == SET_LLF || s == SET_ULF) ? r : r % 2;
        m = (s == SET_CAL && r == 2) ? 16'h0006 : 16'h0002 << i;
        src(s[2:0], i, r, 1'b1);
        rd(s[2:0], OP_COND_RD, m);
        rd(s[2:0], OP_COND_RD, m);
        rd(SET_TOP, OP_COND_RD, top_bit[s]);
        rd(s[2:0], OP_EVT_RD, m);
        rd(s[2:0], OP_EVT_RD, 16'h0000);
        if (r == 3) req(s[2:0], OP_FALL_WR, 16'h7fff);
        src(s[2:0], i, r, 1'b0);
        rd(s[2:0], OP_COND_RD, 16'h0000);
        rd(s[2:0], OP_EVT_RD, (r == 3) ? m : 16'h0000);
        rd(SET_TOP, OP_COND_RD, 16'h0000);
      end
    src(SET_MEAS, 0, 0, 1'b1);
    req(SET_TOP, OP_EN_WR, 16'hffff);
    repeat (2) @(negedge ref_clk);
    check("op_summary", 16'h0001, {15'h0, op_summary});
    rd(SET_TOP, OP_EVT_RD, 16'h1c31);
    repeat (3) @(negedge ref_clk);
    check("op_summary", 16'h0000, {15'h0, op_summary});
    src(SET_MEAS, 0, 0, 1'b0);
    for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(negedge ref_clk);
    if (exp_q.size() != 0) check("pending responses", 16'h0, 16'h1);
    results();
  end
endmodule : osr_core_tb_top
